/* File: rtl/pmrs_consts.svh */
`ifndef PMRS_CONSTS_SVH
`define PMRS_CONSTS_SVH

// register indices; byte address is four times the index
`define PMRS_IDX_WAKE_REC 6'h0b
`define PMRS_IDX_EXTRA_WAKE 6'h0d
`define PMRS_IDX_STATUS 6'h10

// wake recovery register fields
`define PMRS_WR_DIV16 0
`define PMRS_WR_NODIV2 1
`define PMRS_WR_SRC_LO 2
`define PMRS_WR_SRC_HI 4
`define PMRS_WR_DELAY 5
`define PMRS_WR_LEVEL 6
`define PMRS_WR_WARM 7
`define PMRS_WR_RESET 7'h20
`define PMRS_EX_RESET 2'h0

// wake source codes
`define PMRS_SRC_NONE 3'h0
`define PMRS_SRC_RSVD 3'h1
`define PMRS_SRC_P31 3'h2
`define PMRS_SRC_P32 3'h3
`define PMRS_SRC_P33 3'h4
`define PMRS_SRC_P27 3'h5
`define PMRS_SRC_NOR4 3'h6
`define PMRS_SRC_NOR8 3'h7
`define PMRS_EX_OFF 2'h0
`define PMRS_EX_AND4 2'h1
`define PMRS_EX_AND8 2'h2

// opcodes watched on the fetch stream
`define PMRS_OP_NOP 8'hff
`define PMRS_OP_SLEEP 8'h6f
`define PMRS_OP_IDLE 8'h7f
`define PMRS_RESTART_ADDR 16'h000c

// timing: reset delay time and clock rate
`define PMRS_CLK_MHZ 200
`define PMRS_TPOR_US 25
`define PMRS_DIV16_LAST 4'hf

`endif

/* File: rtl/pmrs_pkg.sv */
package pmrs_pkg;

  typedef enum logic [1:0] {
    PMRS_DELAY,
    PMRS_RUN,
    PMRS_IDLE,
    PMRS_SLEEP
  } pmrs_state_t;

  // wake-capable pins
  typedef struct packed {
    logic [3:1] port3;
    logic [7:0] port2;
  } pmrs_wake_pins_t;

  // clock gating view toward the core and oscillator
  typedef struct packed {
    logic cpuClkEn;
    logic timerClkEn;
    logic oscEnable;
    logic holdExec;
  } pmrs_clk_ctl_t;

endpackage : pmrs_pkg

/* File: rtl/pmrs_clk_div.sv */
`timescale 1ns/10ps
`include "pmrs_consts.svh"

module pmrs_clk_div (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic run,
  input wire logic noDiv2,
  input wire logic div16,
  output logic tick
);

  logic halfPhase;
  logic [3:0] preCount;
  logic baseTick;

  // divide-by-two unless bypassed
  assign baseTick = run & (noDiv2 | halfPhase);

  // half-rate phase toggle
  always_ff @(posedge core_clk) begin
    if (!rst_b || !run) begin
      halfPhase <= 1'b0;
    end else begin
      halfPhase <= ~halfPhase;
    end
  end

  // divide-by-16 prescaler on the base rate
  always_ff @(posedge core_clk) begin
    if (!rst_b || !run) begin
      preCount <= 4'h0;
    end else if (baseTick) begin
      preCount <= preCount + 4'h1;
    end
  end

  assign tick = div16 ? (baseTick && preCount == `PMRS_DIV16_LAST) : baseTick;

endmodule : pmrs_clk_div

/* File: rtl/pmrs_wake_sel.sv */
`timescale 1ns/10ps
`include "pmrs_consts.svh"

module pmrs_wake_sel (
  input pmrs_pkg::pmrs_wake_pins_t pins,
  input wire logic [2:0] source,
  input wire logic [1:0] extraSource,
  input wire logic levelHigh,
  output logic wakeRaw
);

  logic selected;
  logic valid;

  // pure gates: no clock runs while the oscillator is stopped
  always_comb begin
    selected = 1'b0;
    valid = 1'b1;
    case (source)
      `PMRS_SRC_P31: selected = pins.port3[1];
      `PMRS_SRC_P32: selected = pins.port3[2];
      `PMRS_SRC_P33: selected = pins.port3[3];
      `PMRS_SRC_P27: selected = pins.port2[7];
      `PMRS_SRC_NOR4: selected = ~|pins.port2[3:0];
      `PMRS_SRC_NOR8: selected = ~|pins.port2;
      default: valid = 1'b0;
    endcase
    // second register sources apply only when the first selects none or the reserved code
    if (!valid) begin
      valid = 1'b1;
      case (extraSource)
        `PMRS_EX_AND4: selected = &pins.port2[3:0];
        `PMRS_EX_AND8: selected = &pins.port2;
        default: valid = 1'b0;
      endcase
    end
  end

  // level compare against the chosen polarity
  assign wakeRaw = valid & (selected == levelHigh);

endmodule : pmrs_wake_sel

/* File: rtl/pmrs_sequencer.sv */
// Implementation choice: the APB register port.
`timescale 1ns/10ps
`include "pmrs_consts.svh"

module pmrs_sequencer #(
  parameter int PorDelayCycles = `PMRS_TPOR_US * `PMRS_CLK_MHZ,
  parameter int DelayWidth = 16
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic powerGood,
  input wire logic watchdogTimeout,
  input wire logic rcTick,
  input wire logic delayUseCrystal,
  input wire logic [7:0] opcode,
  input wire logic opcodeValid,
  input wire logic intServiced,
  input pmrs_pkg::pmrs_wake_pins_t wakePins,
  output pmrs_pkg::pmrs_clk_ctl_t clkCtl,
  output logic restartPulse,
  output logic [15:0] restartAddr,
  output logic [1:0] seqState
);

  localparam logic [DelayWidth-1:0] DelayLast = DelayWidth'(PorDelayCycles - 1);

  pmrs_pkg::pmrs_state_t state;
  pmrs_pkg::pmrs_state_t next_state;
  logic [6:0] wakeRec;
  logic [1:0] extraWake;
  logic warm;
  logic [DelayWidth-1:0] delayCount;
  logic delayTick;
  logic delayDone;
  logic powerGoodSeen;
  logic powerOn;
  logic nopSeen;
  logic wakeRaw;
  logic wakeMeta;
  logic wakeSync;
  logic wakeEvent;
  logic wdtEvent;
  logic enterSleep;
  logic enterIdle;
  logic tick;
  logic clocksRun;
  logic apbWrite;
  logic apbRead;
  logic [5:0] regIdx;
  logic addrHit;

  // bus decode; word addressing only
  assign regIdx = paddr[7:2];
  assign addrHit = (regIdx == `PMRS_IDX_WAKE_REC) || (regIdx == `PMRS_IDX_EXTRA_WAKE) ||
                   (regIdx == `PMRS_IDX_STATUS);
  assign apbWrite = psel & penable & pwrite & addrHit;
  assign apbRead = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addrHit;

  // power-fail to power-good edge detect
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      powerGoodSeen <= 1'b0;
    end else begin
      powerGoodSeen <= powerGood;
    end
  end

  assign powerOn = powerGood & ~powerGoodSeen;
  assign wdtEvent = watchdogTimeout & powerGood;

  // wake source decode, gates only
  pmrs_wake_sel u_wake_sel (
    .pins(wakePins),
    .source(wakeRec[`PMRS_WR_SRC_HI:`PMRS_WR_SRC_LO]),
    .extraSource(extraWake),
    .levelHigh(wakeRec[`PMRS_WR_LEVEL]),
    .wakeRaw(wakeRaw)
  );

  // two-flop synchroniser onto the restarted clock
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      wakeMeta <= 1'b0;
      wakeSync <= 1'b0;
    end else begin
      wakeMeta <= wakeRaw;
      wakeSync <= wakeMeta;
    end
  end

  assign wakeEvent = (state == pmrs_pkg::PMRS_SLEEP) & wakeSync;

  // nop-then-sleep and nop-then-idle detection on the executed opcode stream
  always_ff @(posedge core_clk) begin
    if (!rst_b || state != pmrs_pkg::PMRS_RUN) begin
      nopSeen <= 1'b0;
    end else if (opcodeValid) begin
      nopSeen <= (opcode == `PMRS_OP_NOP);
    end
  end

  assign enterSleep = nopSeen & opcodeValid & (opcode == `PMRS_OP_SLEEP);
  assign enterIdle = nopSeen & opcodeValid & (opcode == `PMRS_OP_IDLE);

  // delay timer tick: crystal rate or rc oscillator pulse
  assign delayTick = delayUseCrystal ? 1'b1 : rcTick;
  assign delayDone = delayTick && (delayCount == DelayLast);

  // delay counter; restarts on each entry to the delay and on power loss, not on a watchdog timeout during the delay
  always_ff @(posedge core_clk) begin
    if (!rst_b || !powerGood) begin
      delayCount <= '0;
    end else if (state != pmrs_pkg::PMRS_DELAY || next_state != pmrs_pkg::PMRS_DELAY) begin
      delayCount <= '0;
    end else if (delayTick) begin
      delayCount <= delayCount + 1'b1;
    end
  end

  // sequencer next state
  always_comb begin
    next_state = state;
    case (state)
      pmrs_pkg::PMRS_DELAY: begin
        if (powerGood && delayDone) begin
          next_state = pmrs_pkg::PMRS_RUN;
        end
      end
      pmrs_pkg::PMRS_RUN: begin
        if (wdtEvent) begin
          next_state = pmrs_pkg::PMRS_DELAY;
        end else if (enterSleep) begin
          next_state = pmrs_pkg::PMRS_SLEEP;
        end else if (enterIdle) begin
          next_state = pmrs_pkg::PMRS_IDLE;
        end
      end
      pmrs_pkg::PMRS_IDLE: begin
        if (wdtEvent) begin
          next_state = pmrs_pkg::PMRS_DELAY;
        end else if (intServiced) begin
          next_state = pmrs_pkg::PMRS_RUN;
        end
      end
      pmrs_pkg::PMRS_SLEEP: begin
        if (wdtEvent) begin
          next_state = pmrs_pkg::PMRS_DELAY;
        end else if (wakeEvent && wakeRec[`PMRS_WR_DELAY]) begin
          next_state = pmrs_pkg::PMRS_DELAY;
        end else if (wakeEvent) begin
          next_state = pmrs_pkg::PMRS_RUN;
        end
      end
      default: next_state = pmrs_pkg::PMRS_DELAY;
    endcase
    // a power drop or power-on edge always forces the full delay
    if (!powerGood || powerOn) begin
      next_state = pmrs_pkg::PMRS_DELAY;
    end
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state <= pmrs_pkg::PMRS_DELAY;
    end else begin
      state <= next_state;
    end
  end

  // restart strobe: vector restart unless idle resumes by interrupt
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      restartPulse <= 1'b0;
    end else begin
      restartPulse <= (next_state == pmrs_pkg::PMRS_RUN) &&
                      (state == pmrs_pkg::PMRS_DELAY || state == pmrs_pkg::PMRS_SLEEP);
    end
  end

  assign restartAddr = `PMRS_RESTART_ADDR;

  // warm-start flag: wake or watchdog out of sleep sets, power-on clears, set wins
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      warm <= 1'b0;
    end else if (state == pmrs_pkg::PMRS_SLEEP && (wakeEvent || wdtEvent)) begin
      warm <= 1'b1;
    end else if (powerOn) begin
      warm <= 1'b0;
    end
  end

  // wake recovery register; divide-by-16 bit cleared by recoveries
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      wakeRec <= `PMRS_WR_RESET;
    end else if (apbWrite && regIdx == `PMRS_IDX_WAKE_REC) begin
      wakeRec <= pwdata[6:0];
    end else if (powerOn || wdtEvent || (state == pmrs_pkg::PMRS_SLEEP && wakeEvent)) begin
      wakeRec[`PMRS_WR_DIV16] <= 1'b0;
    end
  end

  // extra wake source register, write only
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      extraWake <= `PMRS_EX_RESET;
    end else if (apbWrite && regIdx == `PMRS_IDX_EXTRA_WAKE) begin
      extraWake <= pwdata[1:0];
    end
  end

  // read data: only the warm flag of the recovery register reads back
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      case (regIdx)
        `PMRS_IDX_WAKE_REC: prdata <= {24'h0, warm, 7'h0};
        `PMRS_IDX_STATUS: prdata <= {28'h0, wakeSync, powerGood, state};
        default: prdata <= 32'h0;
      endcase
    end
  end

  // system and timer clock enables with divide options
  assign clocksRun = (state != pmrs_pkg::PMRS_SLEEP) && powerGood;

  pmrs_clk_div u_clk_div (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .run(clocksRun),
    .noDiv2(wakeRec[`PMRS_WR_NODIV2]),
    .div16(wakeRec[`PMRS_WR_DIV16]),
    .tick(tick)
  );

  // gating outputs toward core, timers and oscillator
  always_comb begin
    clkCtl.timerClkEn = tick;
    clkCtl.cpuClkEn = tick && state == pmrs_pkg::PMRS_RUN;
    clkCtl.oscEnable = state != pmrs_pkg::PMRS_SLEEP;
    clkCtl.holdExec = state == pmrs_pkg::PMRS_DELAY;
  end

  assign seqState = state;

  // unused bus bits kept quiet
  logic unusedBits;
  assign unusedBits = ^{pwdata[31:7], apbRead, paddr[1:0]};

endmodule : pmrs_sequencer

/* File: tb/pmrs_asserts.sv */
`timescale 1ns/10ps
module pmrs_asserts (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pslverr,
  input wire logic powerGood,
  input wire logic watchdogTimeout,
  input wire logic [7:0] opcode,
  input wire logic opcodeValid,
  input wire logic intServiced,
  input pmrs_pkg::pmrs_clk_ctl_t clkCtl,
  input wire logic restartPulse,
  input wire logic [15:0] restartAddr,
  input wire logic [1:0] seqState
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  property p_unmapped;
    psel && penable && !(paddr[7:2] inside {6'h0b, 6'h0d, 6'h10}) |-> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_addr;
    restartPulse |-> restartAddr == 16'h000c && seqState == 2'h1;
  endproperty
  a_addr: assert property (p_addr) else $error("bad restart");
  property p_sleep;
    seqState == 2'h3 |-> !clkCtl.oscEnable && !clkCtl.cpuClkEn;
  endproperty
  a_sleep: assert property (p_sleep) else $error("clock alive in sleep");
  property p_idle;
    seqState == 2'h2 |-> clkCtl.oscEnable && !clkCtl.cpuClkEn;
  endproperty
  a_idle: assert property (p_idle) else $error("idle gating wrong");
  property p_hold;
    seqState == 2'h0 |-> clkCtl.holdExec;
  endproperty
  a_hold: assert property (p_hold) else $error("execution not held");
  property p_wd;
    watchdogTimeout && powerGood && seqState != 2'h0 |=> seqState == 2'h0;
  endproperty
  a_wd: assert property (p_wd) else $error("watchdog missed");
  property p_stay;
    seqState == 2'h2 && !intServiced && !watchdogTimeout && powerGood |=> seqState == 2'h2;
  endproperty
  a_stay: assert property (p_stay) else $error("idle left early");
  property p_enter;
    seqState == 2'h3 && $past(seqState) == 2'h1 |-> $past(opcodeValid && opcode == 8'h6f);
  endproperty
  a_enter: assert property (p_enter) else $error("sleep without opcode");
endmodule : pmrs_asserts

bind pmrs_sequencer pmrs_asserts u_asserts (.core_clk, .rst_b, .psel, .penable, .paddr,
  .pslverr, .powerGood, .watchdogTimeout, .opcode, .opcodeValid, .intServiced, .clkCtl,
  .restartPulse, .restartAddr, .seqState);

/* File: tb/pmrs_osc_wake.sv */
`timescale 1ns/10ps
module pmrs_osc_wake (
  input wire logic core_clk,
  input wire logic pinLevel,
  output logic rcTick,
  output pmrs_pkg::pmrs_wake_pins_t wakePins
);
  logic [1:0] rcDiv = 2'h0;
  // free running rc oscillator, ticks every fourth cycle
  always_ff @(posedge core_clk) begin
    rcDiv <= rcDiv + 2'h1;
  end
  assign rcTick = (rcDiv == 2'h3);
  // all wake pins follow one level; crystal kept at the core rate, below the bypass limit
  assign wakePins = {{3{pinLevel}}, {8{pinLevel}}};
endmodule : pmrs_osc_wake

/* File: tb/power_mode_reset_sequencer_tb.sv */
`timescale 1ns/10ps
`define CHK(g, e, m) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH t=%0t %s", $time, m); end end
module power_mode_reset_sequencer_tb;
  logic core_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00, opcode = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, restartPulse, rcTick, sawDelay, wl, pinLevel = 0;
  logic powerGood = 0, watchdogTimeout = 0, delayUseCrystal = 0, opcodeValid = 0;
  logic intServiced = 0;
  logic [15:0] restartAddr;
  logic [1:0] seqState;
  pmrs_pkg::pmrs_wake_pins_t wakePins;
  pmrs_pkg::pmrs_clk_ctl_t clkCtl;
  int fail_count = 0, checks = 0, cyc = 0, n;
  pmrs_sequencer #(.PorDelayCycles(8)) dut (.core_clk, .rst_b, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .powerGood, .watchdogTimeout, .rcTick,
    .delayUseCrystal, .opcode, .opcodeValid, .intServiced, .wakePins, .clkCtl,
    .restartPulse, .restartAddr, .seqState);
  pmrs_osc_wake u_far (.core_clk, .pinLevel, .rcTick, .wakePins);
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  // cycle ceiling and delay watcher
  always @(posedge core_clk) begin
    cyc++;
    if (seqState === 2'h0) sawDelay = 1;
    if (cyc == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end
  task report_and_stop();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    do @(posedge core_clk); while (pready !== 1'b1);
    r = prdata;
    psel <= 0; penable <= 0;
  endtask : apb
  task ops(input logic [7:0] a, input logic [7:0] b);
    @(posedge core_clk);
    opcode <= a; opcodeValid <= 1;
    @(posedge core_clk);
    opcode <= b;
    @(posedge core_clk);
    opcodeValid <= 0;
    // one more edge so the state taken on the last opcode has settled
    @(posedge core_clk);
  endtask : ops
  // one-cycle pulse on the watchdog (wd high) or on interrupt service
  task pulse(input bit wd);
    @(posedge core_clk);
    if (wd) watchdogTimeout <= 1;
    else intServiced <= 1;
    @(posedge core_clk);
    watchdogTimeout <= 0;
    intServiced <= 0;
  endtask : pulse
  task waitRestart();
    n = 0;
    do begin @(posedge core_clk); n++; end while (restartPulse !== 1'b1 && n < 400);
    `CHK(restartPulse, 1'b1, "no restart")
  endtask : waitRestart
  task cnt(input logic [7:0] v, input int e);
    int c;
    c = 0;
    if (v != 8'h00) apb(1, 8'h2c, {24'h0, v}); // zero keeps the register as left
    repeat (32) begin @(posedge core_clk); if (clkCtl.cpuClkEn === 1'b1) c++; end
    `CHK(c, e, "clock rate")
  endtask : cnt
  initial begin
    repeat (2) @(posedge core_clk);
    rst_b <= 1; powerGood <= 1;
    waitRestart();
    `CHK(n >= 28, 1'b1, "delay too short on rc ticks")
    delayUseCrystal <= 1;
    apb(0, 8'h00, 0);
    `CHK(pslverr, 1'b1, "unmapped")
    apb(1, 8'h2c, 32'h7f);
    apb(0, 8'h2c, 0);
    `CHK(r, 32'h0, "write-only bits read back")
    apb(1, 8'h34, 0);
    ops(8'h11, 8'h7f);
    `CHK(seqState, 2'h1, "idle without nop")
    ops(8'hff, 8'h7f);
    `CHK(seqState, 2'h2, "idle entry")
    pulse(0);
    @(posedge core_clk);
    `CHK(seqState, 2'h1, "idle exit")
    `CHK(restartPulse, 1'b0, "idle exit restarts")
    ops(8'hff, 8'h7f);
    pulse(1);
    waitRestart();
    for (int s = 0; s < 8; s++) begin
      // waking pin level: the chosen level, inverted through the nor sources
      wl = s[0] ^ (s >= 6);
      pinLevel <= ~wl;
      apb(1, 8'h2c, {24'h0, 1'b0, s[0], (s == 7), s[2:0], 2'b11});
      ops(8'hff, 8'h6f);
      sawDelay = 0;
      `CHK(clkCtl.oscEnable, 1'b0, "sleep osc")
      pinLevel <= wl;
      if (s < 2) begin
        repeat (6) @(posedge core_clk);
        `CHK(seqState, 2'h3, "disabled source woke")
        pulse(1);
      end
      waitRestart();
      `CHK(sawDelay, (s < 2 || s == 7), "delay bypass")
      apb(0, 8'h2c, 0);
      `CHK(r, 32'h80, "warm flag")
    end
    cnt(8'h00, 32);
    cnt(8'h22, 32);
    cnt(8'h20, 16);
    cnt(8'h23, 2);
    @(posedge core_clk);
    powerGood <= 0;
    repeat (3) @(posedge core_clk);
    powerGood <= 1;
    waitRestart();
    apb(0, 8'h2c, 0);
    `CHK(r, 32'h0, "cold flag")
    apb(0, 8'h40, 0);
    `CHK(r, 32'h5, "status word")
    report_and_stop();
  end
endmodule : power_mode_reset_sequencer_tb
